// file: design/bcce_defs.vh
// constants for the branch, call, clear and complement execute block
//
// Overview of operation
// - upper byte 1110 0000 branches on zero, low byte offset -128..127
// - zero set loads pc plus two plus twice offset, else next word
// - untaken branch one cycle, taken two with nop, flags untouched
// - call is two words: 1110 110s k7..0, then 1111 k19..8
// - call pushes pc plus four, then loads 20-bit target into pc 20:1
// - shadow bit one copies accumulator, flags, bank select into shadows
// - call takes two cycles; second reads high target, writes pc
// - clear-register opcode 0110 101a, low byte selects data location
// - clear writes zero, sets zero flag, reads q2 writes q4
// - access bit zero uses access bank, one uses bank select register
// - extended set, access zero, address up to 5fh uses indexed offset
// - watchdog restart clears counter, postscaler, sets both status flags
// - complement inverts register to accumulator or register, sets n, z
`ifndef BCCE_DEFS_VH
`define BCCE_DEFS_VH
`define BCCE_OP_BRZERO    8'he0
`define BCCE_OP_CALL      7'h76
`define BCCE_OP_CALL2     4'hf
`define BCCE_OP_CLRREG    7'h35
`define BCCE_OP_COMPL     6'h07
`define BCCE_OP_WDRESTART 16'h0004
`define BCCE_ILO_MAX      8'h5f
`define BCCE_ACC_HI_BIT   8'h80
`define BCCE_ACC_HI_BANK  4'hf
`define BCCE_PC_RST       21'h000000
`define BCCE_REG_RST      8'h00
`define BCCE_FLAG_Z       2
`define BCCE_FLAG_N       4
`define BCCE_Q_DEC        2'h0
`define BCCE_Q_RD         2'h1
`define BCCE_Q_PROC       2'h2
`define BCCE_Q_WR         2'h3
`endif

// file: design/bcce_exec.v
// execute logic for branch-on-zero, call, clear, watchdog restart, complement
`timescale 1ns/1ps
`include "bcce_defs.vh"
module bcce_exec (
    input  wire        CORE_CLK_IN,
    input  wire        SYS_RST_IN,
    input  wire [15:0] OPCODE_IN,
    input  wire        EXT_SET_EN_IN,
    input  wire [7:0]  ACCUM_IN,
    input  wire [7:0]  STATUS_IN,
    input  wire [3:0]  BANK_SELECT_IN,
    input  wire [7:0]  FSR2_BASE_IN,
    input  wire [7:0]  MEM_RDATA_IN,
    output wire [1:0]  QPHASE_OUT,
    output wire        FETCH_OUT,
    output wire [20:0] PC_OUT,
    output wire [20:0] STACK_PUSH_DATA_OUT,
    output wire        STACK_PUSH_OUT,
    output wire [11:0] MEM_ADDR_OUT,
    output wire        MEM_RD_OUT,
    output wire        MEM_WR_OUT,
    output wire [7:0]  MEM_WDATA_OUT,
    output wire        ACCUM_WR_OUT,
    output wire [7:0]  ACCUM_WDATA_OUT,
    output wire        STATUS_WR_OUT,
    output wire [7:0]  STATUS_WDATA_OUT,
    output wire [7:0]  ACCUMULATOR_SHADOW_OUT,
    output wire [7:0]  FLAGS_SHADOW_OUT,
    output wire [3:0]  BANK_SELECT_SHADOW_OUT,
    output wire        WATCHDOG_RESTART_OUT,
    output wire        TIMEOUT_FLAG_N_OUT,
    output wire        POWERDOWN_FLAG_N_OUT,
    output wire        ILLEGAL_OUT
);

    // =====================================================================
    // state codes
    localparam ST_EXEC  = 2'h0;
    localparam ST_NOP   = 2'h1;
    localparam ST_CALL2 = 2'h2;

    reg  [1:0]  q_reg;
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [15:0] ir_reg;
    reg  [20:0] pc_reg;
    reg  [20:0] pc_next;
    reg  [7:0]  acc_sh_reg;
    reg  [7:0]  ss_reg;
    reg  [3:0]  bs_reg;
    reg         shadow_reg;
    reg  [7:0]  klo_reg;
    reg  [20:0] push_data_reg;
    reg         push_reg;
    reg  [11:0] addr_reg;
    reg         rd_reg;
    reg         wr_reg;
    reg  [7:0]  wdata_reg;
    reg         acc_wr_reg;
    reg  [7:0]  acc_data_reg;
    reg         st_wr_reg;
    reg  [7:0]  st_data_reg;
    reg         wdog_reg;
    reg         to_n_reg;
    reg         pwrdn_n_reg;
    reg         ill_reg;
    reg  [7:0]  comp_val;
    reg  [7:0]  st_comp;
    reg  [11:0] addr_next;

    // =====================================================================
    // decode of the latched opcode
    wire        is_branch = ir_reg[15:8] == `BCCE_OP_BRZERO;
    wire        is_call  = ir_reg[15:9] == `BCCE_OP_CALL;
    wire        is_clear = ir_reg[15:9] == `BCCE_OP_CLRREG;
    wire        is_compl = ir_reg[15:10] == `BCCE_OP_COMPL;
    wire        is_wdog  = ir_reg == `BCCE_OP_WDRESTART;
    wire        in_exec  = state_reg == ST_EXEC;
    wire        zero_set = STATUS_IN[`BCCE_FLAG_Z];
    wire        taken    = in_exec && is_branch && zero_set;
    wire [20:0] offs2    = {{12{ir_reg[7]}}, ir_reg[7:0], 1'b0};

    // file address forming for byte instructions
    always @* begin
        if (!ir_reg[8] && EXT_SET_EN_IN && ir_reg[7:0] <= `BCCE_ILO_MAX) begin
            addr_next = {4'h0, FSR2_BASE_IN + ir_reg[7:0]};
        end else if (!ir_reg[8]) begin
            addr_next = {(ir_reg[7:0] >= `BCCE_ACC_HI_BIT) ?
                         `BCCE_ACC_HI_BANK : 4'h0, ir_reg[7:0]};
        end else begin
            addr_next = {BANK_SELECT_IN, ir_reg[7:0]};
        end
    end

    // complement result and its flags
    always @* begin
        comp_val = ~MEM_RDATA_IN;
        st_comp = STATUS_IN;
        st_comp[`BCCE_FLAG_N] = comp_val[7];
        st_comp[`BCCE_FLAG_Z] = (comp_val == 8'h00);
    end

    // =====================================================================
    // sequencing between instruction cycles
    always @* begin
        state_next = ST_EXEC;
        pc_next = pc_reg + 21'h000002;
        case (state_reg)
            ST_EXEC: begin
                if (taken) begin
                    pc_next = pc_reg + offs2;
                    state_next = ST_NOP;
                end else if (is_call) begin
                    state_next = ST_CALL2;
                end
            end
            ST_CALL2: begin
                // second word taken as operand only
                pc_next = {ir_reg[11:0], klo_reg, 1'b0};
            end
            default: begin
                state_next = ST_EXEC;
            end
        endcase
    end

    // quarter counter, pc and instruction register
    always @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            q_reg     <= `BCCE_Q_DEC;
            state_reg <= ST_EXEC;
            pc_reg    <= `BCCE_PC_RST;
            ir_reg    <= 16'h0000;
            klo_reg   <= `BCCE_REG_RST;
            shadow_reg <= 1'b0;
        end else begin
            q_reg <= q_reg + 2'h1;
            if (q_reg == `BCCE_Q_WR) begin
                state_reg <= state_next;
                pc_reg    <= pc_next;
                // nop cycle replaces the word fetched under a taken branch
                ir_reg <= taken ? 16'h0000 : OPCODE_IN;
                if (in_exec && is_call) begin
                    klo_reg    <= ir_reg[7:0];
                    shadow_reg <= ir_reg[8];
                end
            end
        end
    end

    // =====================================================================
    // data-path side effects per quarter
    always @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            push_data_reg <= `BCCE_PC_RST;
            push_reg <= 1'b0;
            addr_reg <= 12'h000;
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            wdata_reg <= `BCCE_REG_RST;
            acc_wr_reg <= 1'b0;
            acc_data_reg <= `BCCE_REG_RST;
            st_wr_reg <= 1'b0;
            st_data_reg <= `BCCE_REG_RST;
            acc_sh_reg <= `BCCE_REG_RST;
            ss_reg <= `BCCE_REG_RST;
            bs_reg <= 4'h0;
            wdog_reg <= 1'b0;
            to_n_reg <= 1'b1;
            pwrdn_n_reg <= 1'b1;
            ill_reg <= 1'b0;
        end else begin
            push_reg <= 1'b0;
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            acc_wr_reg <= 1'b0;
            st_wr_reg <= 1'b0;
            wdog_reg <= 1'b0;
            ill_reg <= 1'b0;
            if (in_exec && q_reg == `BCCE_Q_RD && (is_clear || is_compl)) begin
                addr_reg <= addr_next;
                rd_reg <= 1'b1;
            end
            if (in_exec && q_reg == `BCCE_Q_PROC) begin
                if (is_call) begin
                    // pc already points past word one
                    push_data_reg <= pc_reg + 21'h000002;
                    push_reg <= 1'b1;
                    if (ir_reg[8]) begin
                        acc_sh_reg <= ACCUM_IN;
                        ss_reg <= STATUS_IN;
                        bs_reg <= BANK_SELECT_IN;
                    end
                end
                if (is_clear) begin
                    wdata_reg <= `BCCE_REG_RST;
                    st_data_reg <= STATUS_IN |
                                   (8'h01 << `BCCE_FLAG_Z);
                end
                if (is_compl) begin
                    wdata_reg <= comp_val;
                    acc_data_reg <= comp_val;
                    st_data_reg <= st_comp;
                end
            end
            if (in_exec && q_reg == `BCCE_Q_WR) begin
                if (is_clear) begin
                    wr_reg <= 1'b1;
                    st_wr_reg <= 1'b1;
                end
                if (is_compl) begin
                    wr_reg <= ir_reg[9];
                    acc_wr_reg <= !ir_reg[9];
                    st_wr_reg <= 1'b1;
                end
                if (is_wdog) begin
                    wdog_reg <= 1'b1;
                    to_n_reg <= 1'b1;
                    pwrdn_n_reg <= 1'b1;
                end
                // a lone second call word is never executed
                if (ir_reg[15:12] == `BCCE_OP_CALL2) begin
                    ill_reg <= 1'b1;
                end
            end
        end
    end

    // =====================================================================
    // outputs
    assign QPHASE_OUT = q_reg;
    assign FETCH_OUT = q_reg == `BCCE_Q_WR;
    assign PC_OUT = pc_reg;
    assign STACK_PUSH_DATA_OUT = push_data_reg;
    assign STACK_PUSH_OUT = push_reg;
    assign MEM_ADDR_OUT = addr_reg;
    assign MEM_RD_OUT = rd_reg;
    assign MEM_WR_OUT = wr_reg;
    assign MEM_WDATA_OUT = wdata_reg;
    assign ACCUM_WR_OUT = acc_wr_reg;
    assign ACCUM_WDATA_OUT = acc_data_reg;
    assign STATUS_WR_OUT = st_wr_reg;
    assign STATUS_WDATA_OUT = st_data_reg;
    assign ACCUMULATOR_SHADOW_OUT = acc_sh_reg;
    assign FLAGS_SHADOW_OUT = ss_reg;
    assign BANK_SELECT_SHADOW_OUT = bs_reg;
    assign WATCHDOG_RESTART_OUT = wdog_reg;
    assign TIMEOUT_FLAG_N_OUT = to_n_reg;
    assign POWERDOWN_FLAG_N_OUT = pwrdn_n_reg;
    assign ILLEGAL_OUT = ill_reg;

endmodule // bcce_exec

// file: verif/bcce_exec_monitor.sv
// assertion checker bound to the bcce_exec ports
`timescale 1ns/1ps
`include "bcce_defs.vh"
module bcce_exec_monitor (
    input logic        CORE_CLK_IN,
    input logic        SYS_RST_IN,
    input logic [15:0] OPCODE_IN,
    input logic [1:0]  QPHASE_OUT,
    input logic        FETCH_OUT,
    input logic [20:0] PC_OUT,
    input logic [20:0] STACK_PUSH_DATA_OUT,
    input logic        STACK_PUSH_OUT,
    input logic        MEM_RD_OUT,
    input logic        MEM_WR_OUT,
    input logic [7:0]  MEM_WDATA_OUT,
    input logic        STATUS_WR_OUT,
    input logic [7:0]  STATUS_WDATA_OUT
);
    // ==========
    // last two captured words
    logic [15:0] op_last_reg;
    logic [15:0] op_prev_reg;
    logic [19:0] call_k;
    assign call_k = {op_last_reg[11:0], op_prev_reg[7:0]};
    always @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            op_last_reg <= 16'h0000;
            op_prev_reg <= 16'h0000;
        end else if (FETCH_OUT) begin
            op_last_reg <= OPCODE_IN;
            op_prev_reg <= op_last_reg;
        end
    end
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // ==========
    // assertions
    a_phase_step: assert property (
        !$past(SYS_RST_IN) |-> QPHASE_OUT == $past(QPHASE_OUT) + 2'h1)
        else $error("quarter phase skipped");
    a_fetch_last: assert property (
        FETCH_OUT == (QPHASE_OUT == 2'h3)) else $error("fetch off q4");
    a_read_q2: assert property (
        MEM_RD_OUT |-> QPHASE_OUT == 2'h2) else $error("read off q2");
    a_write_after_read: assert property (
        MEM_WR_OUT |-> QPHASE_OUT == 2'h0 && $past(MEM_RD_OUT, 2))
        else $error("write not after read");
    a_clear_zero: assert property (
        MEM_WR_OUT && op_prev_reg[15:9] == `BCCE_OP_CLRREG |->
        MEM_WDATA_OUT == 8'h00 && STATUS_WR_OUT && STATUS_WDATA_OUT[2])
        else $error("clear wrote wrong data");
    a_push_data: assert property (
        STACK_PUSH_OUT |-> STACK_PUSH_DATA_OUT == $past(PC_OUT, 2) + 21'h2)
        else $error("return address wrong");
    a_call_target: assert property (
        STACK_PUSH_OUT |-> ##5 PC_OUT == {$past(call_k), 1'b0})
        else $error("call target wrong");
    a_branch_quiet: assert property (
        FETCH_OUT && op_last_reg[15:8] == `BCCE_OP_BRZERO |=>
        !STATUS_WR_OUT && !MEM_WR_OUT) else $error("branch wrote state");
    c_call: cover property (STACK_PUSH_OUT);
    c_write: cover property (MEM_WR_OUT && STATUS_WR_OUT);
    c_branch: cover property (FETCH_OUT && op_last_reg[15:8] == 8'he0);
endmodule // bcce_exec_monitor
bind bcce_exec bcce_exec_monitor i_bcce_exec_monitor (
    .CORE_CLK_IN, .SYS_RST_IN, .OPCODE_IN, .QPHASE_OUT, .FETCH_OUT,
    .PC_OUT, .STACK_PUSH_DATA_OUT, .STACK_PUSH_OUT, .MEM_RD_OUT,
    .MEM_WR_OUT, .MEM_WDATA_OUT, .STATUS_WR_OUT, .STATUS_WDATA_OUT);

// file: verif/bcce_exec_bench.sv
// self-checking bench for the bcce_exec block
`timescale 1ns/1ps
module bcce_exec_bench;
    // ==========
    // stimulus and observed signals
    logic        clk, rst, ext, push, mw, sw, aw, wd, il, ton_n, pdn_n;
    logic [15:0] op;
    logic [7:0]  acc, stat, base, rd, md, sd, ad, wsh, fsh;
    logic [3:0]  bank, bsh;
    logic [4:0]  seen;
    logic [1:0]  q;
    logic [20:0] pc, push_d, p, e;
    logic [11:0] ma;
    int          err_count, checks_done;
    logic [15:0] cw [4] = '{16'h6a22, 16'h6b44, 16'h6a85, 16'h6a10};
    logic [11:0] ca [4] = '{12'h022, 12'h344, 12'hf85, 12'h030};
    logic [7:0]  bn [3] = '{8'h80, 8'h7f, 8'h05};
    bcce_exec i_bcce_exec (
        .CORE_CLK_IN(clk), .SYS_RST_IN(rst), .OPCODE_IN(op),
        .EXT_SET_EN_IN(ext), .ACCUM_IN(acc), .STATUS_IN(stat),
        .BANK_SELECT_IN(bank), .FSR2_BASE_IN(base), .MEM_RDATA_IN(rd),
        .QPHASE_OUT(q), .FETCH_OUT(), .PC_OUT(pc),
        .STACK_PUSH_DATA_OUT(push_d), .STACK_PUSH_OUT(push),
        .MEM_ADDR_OUT(ma), .MEM_RD_OUT(), .MEM_WR_OUT(mw),
        .MEM_WDATA_OUT(md), .ACCUM_WR_OUT(aw), .ACCUM_WDATA_OUT(ad),
        .STATUS_WR_OUT(sw), .STATUS_WDATA_OUT(sd),
        .ACCUMULATOR_SHADOW_OUT(wsh), .FLAGS_SHADOW_OUT(fsh),
        .BANK_SELECT_SHADOW_OUT(bsh), .WATCHDOG_RESTART_OUT(wd),
        .TIMEOUT_FLAG_N_OUT(ton_n), .POWERDOWN_FLAG_N_OUT(pdn_n),
        .ILLEGAL_OUT(il));
    // ==========
    // clock and sticky pulse record
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) seen <= seen | {push, wd, il, sw, mw};
    // ==========
    // helpers
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // one word, captured at the edge that ends q4
    task automatic issue(input logic [15:0] w);
        do begin @(posedge clk); #1; end while (q !== 2'h2);
        @(posedge clk) op <= w;
        @(posedge clk) op <= 16'h0000;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ==========
    // main sequence
    initial begin
        {rst, op, ext, acc, stat, base, rd, bank, seen} =
            {1'b1, 17'h0, 8'h5a, 8'h10, 8'h20, 8'h13, 4'h3, 5'h00};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        step(0);
        chk(24'({ton_n, pdn_n, wsh, fsh, bsh}), 24'h300000);
        chk(24'(pc), 24'h000000);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) ext <= (i > 1);
            issue(cw[i]);
            step(4);
            chk(24'(ma), 24'(ca[i]));
            chk(24'({mw, sw, md, sd}), 24'h030014);
        end
        seen = 5'h00;
        issue(16'hed34);
        #1 p = pc;
        issue(16'hf12a);
        #1 chk(24'({seen[4], push_d}), 24'({1'b1, p + 21'h2}));
        step(4);
        chk(24'(pc), 24'h025468);
        chk(24'({wsh, fsh, bsh}), 24'h05a103);
        @(posedge clk) acc <= 8'h77;
        issue(16'hec00);
        issue(16'hf000);
        step(4);
        chk(24'({seen[2], pc}), 24'h000000);
        chk(24'({wsh, fsh, bsh}), 24'h05a103);
        @(posedge clk) stat <= 8'h04;
        for (int i = 0; i < 3; i++) begin
            if (i == 2) @(posedge clk) stat <= 8'h00;
            issue({8'he0, bn[i]});
            #1 p = pc;
            seen = 4'h0;
            issue(16'h6a05);
            #1 e = (i < 2) ? p + {{12{bn[i][7]}}, bn[i], 1'b0} : p + 21'h2;
            chk(24'(pc), 24'(e));
            step(8);
            chk(24'(seen[1:0]), (i < 2) ? 24'h0 : 24'h3);
        end
        seen = 4'h0;
        issue(16'h0004);
        step(8);
        chk(24'({seen, ton_n, pdn_n}), 24'h000023);
        @(posedge clk) stat <= 8'h04;
        issue(16'h1c22);
        step(4);
        chk(24'({aw, ad, sw, sd}), 24'h03d910);
        finish_test();
    end
    // ==========
    // watchdog against a hang
    initial begin
        #100000;
        err_count++;
        finish_test();
    end
endmodule // bcce_exec_bench
